// *** rtl/sbprx_defines.vh ***
// Constants of the biphase-capable serial receive path
// Function
// [RL1] Biphase decoder runs when the biphase enable field is 1.
// [RL2] Preamble length sets expected preamble; zero turns preamble check off.
// [RL3] Input polarity swaps which transition means zero or one.
// [RL4] Preamble must match the selected pattern.
// [RL5] Single-bit delimiter mode accepts only an encoded zero as start.
// [RL6] Otherwise only a three-bit-time sync waveform is a start.
// [RL7] Start seen when line is low for a quarter bit, glitches rejected.
// [RL8] Each cell sampled at its quarter and three-quarter points.
// [RL9] Match keeps sync; mismatch drops it and waits for next edge.
// [RL10] A bit is decided after at least three quarters of a bit time.
// [RL11] After preamble and delimiter, cells become NRZ bits for the character.
// [RL12] Missing mid-cell transition sets code violation until clear command; the code sets it only in data and parity cells.
// [RL13] Sync mode stores character with sync kind: 1 command, 0 data.
// [RL14] Far side keeps delimiter waveform consistent with line idle level.
// [RL15] Synchronous mode samples on baud edges; low sample starts a character.
// [RL16] Finished character goes to holding register and sets char waiting.
// [RL17] Completion while waiting sets overrun and overwrites; clear command clears.
// [RL18] Even parity: mismatch against even count of ones flags error.
// [RL19] Odd parity: mismatch against odd count of ones flags error.
// [RL20] Mark expects 1, space expects 0; otherwise error.
// [RL21] Parity disabled: no parity bit, never a parity error.
// [RL22] Parity error flag stays until the clear command.
// [RL23] Multidrop: a high parity bit sets the parity error flag.
// [RL24] Preamble patterns: all ones, all zeros, one-zero, zero-one.
// [RL25] Command sync is 1.5 bits high then 1.5 bits low; data sync inverse.
`ifndef SBPRX_DEFINES_VH
`define SBPRX_DEFINES_VH
`define SBPRX_LINE_CONFIG_ADDR    12'h004
`define SBPRX_COMMAND_ADDR        12'h000
`define SBPRX_STATUS_ADDR         12'h014
`define SBPRX_HOLDING_ADDR        12'h018
`define SBPRX_BAUD_DIV_ADDR       12'h020
`define SBPRX_BIPHASE_CONFIG_ADDR 12'h050
`define SBPRX_CMD_CLEAR_BIT       8
`define SBPRX_CMD_RX_EN_BIT       4
`define SBPRX_CMD_RX_DIS_BIT      5
`define SBPRX_CFG_SYNC_BIT        8
`define SBPRX_CFG_PAR_LSB         9
`define SBPRX_CFG_PAR_MSB         11
`define SBPRX_CFG_SINGLE_BIT_DELIMITER_BIT      31
`define SBPRX_CFG_BIPHASE_BIT     29
`define SBPRX_CFG_RESET           32'h00000000
`define SBPRX_BIP_PL_LSB          16
`define SBPRX_BIP_PL_MSB          19
`define SBPRX_BIP_PP_LSB          24
`define SBPRX_BIP_PP_MSB          25
`define SBPRX_BIP_POL_BIT         28
`define SBPRX_BIP_RESET           32'h00000000
`define SBPRX_DIV_RESET           16'h0010
`define SBPRX_ST_RECEIVE_CHAR_WAITING_BIT        0
`define SBPRX_ST_OVR_BIT          5
`define SBPRX_ST_PAR_BIT          7
`define SBPRX_ST_CODE_VIOLATION_FLAG_BIT         24
`define SBPRX_RHR_SYNC_BIT        15
`define SBPRX_PAR_EVEN            3'h0
`define SBPRX_PAR_ODD             3'h1
`define SBPRX_PAR_SPACE           3'h2
`define SBPRX_PAR_MARK            3'h3
`define SBPRX_PAR_NONE            3'h4
`define SBPRX_PP_ONES             2'h0
`define SBPRX_PP_ZEROS            2'h1
`define SBPRX_PP_ONEZERO          2'h2
`define SBPRX_PP_ZEROONE          2'h3
`define SBPRX_DATA_BITS           4'h8
`define SBPRX_QTR_MIN             16'h0001
`endif

// *** rtl/sbprx_receiver.v ***
// Serial receive path: biphase decoder, synchronous sampler, holding register, parity
`include "sbprx_defines.vh"
module sbprx_receiver (
    input  wire        clk,
    input  wire        rst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        serialInputLine,
    input  wire        baudClockIn,
    output reg         receiveCharWaiting
);
    localparam [2:0] S_IDLE = 3'h0, S_PRE = 3'h1, S_DELIM = 3'h2, S_DATA = 3'h3,
                     S_PAR = 3'h4, S_STOP = 3'h5;

    // Registers seen by software
    reg [31:0] lineConfigReg;
    reg [31:0] biphaseConfigReg;
    reg [15:0] baudDiv;
    reg        rxEnabled;
    reg [7:0]  receivedCharField;
    reg        receivedSyncKind;
    reg        overrunFlag;
    reg        parityErrorFlag;
    reg        codeViolationFlag;

    // Input synchronisers
    reg [1:0] lineSync;
    reg [1:0] baudSync;
    reg       baudPrev;

    // Receive engine
    reg [2:0]  state;
    reg [15:0] cellCnt;
    reg [3:0]  bitCnt;
    reg [7:0]  shiftReg;
    reg        firstHalf;
    reg        syncKind;
    reg        charDone;
    reg        doneParErr;
    reg        doneSync;
    reg [7:0]  doneChar;
    reg        violation;

    wire        biphaseOn = lineConfigReg[`SBPRX_CFG_BIPHASE_BIT];
    wire        syncMode  = lineConfigReg[`SBPRX_CFG_SYNC_BIT];
    wire        single_bit_delimiter    = lineConfigReg[`SBPRX_CFG_SINGLE_BIT_DELIMITER_BIT];
    wire [2:0]  parMode   = lineConfigReg[`SBPRX_CFG_PAR_MSB:`SBPRX_CFG_PAR_LSB];
    wire [3:0]  preLen    = biphaseConfigReg[`SBPRX_BIP_PL_MSB:`SBPRX_BIP_PL_LSB];
    wire [1:0]  prePat    = biphaseConfigReg[`SBPRX_BIP_PP_MSB:`SBPRX_BIP_PP_LSB];
    wire        inPol     = biphaseConfigReg[`SBPRX_BIP_POL_BIT];
    wire        lineIn    = lineSync[1] ^ inPol; // RL3
    wire [15:0] quarter   = (baudDiv < `SBPRX_QTR_MIN) ? `SBPRX_QTR_MIN : baudDiv;
    wire [15:0] qtr3      = quarter + quarter + quarter;
    wire [15:0] cellLen   = qtr3 + quarter;
    wire        baudRise  = baudSync[1] & ~baudPrev;
    wire        apbAccess = psel & penable;
    wire        apbWrite  = apbAccess & pwrite & pready;
    wire        clearCmd  = apbWrite && (paddr == `SBPRX_COMMAND_ADDR)
                            && pwdata[`SBPRX_CMD_CLEAR_BIT];
    wire        rhrRead   = apbAccess & ~pwrite & pready && (paddr == `SBPRX_HOLDING_ADDR);

    // Parity error for a finished character
    function parity_bad;
        input [2:0] mode;
        input [7:0] data;
        input       pbit;
        begin
            if (mode == `SBPRX_PAR_EVEN) begin
                parity_bad = pbit != ^data; // RL18
            end else if (mode == `SBPRX_PAR_ODD) begin
                parity_bad = pbit != ~^data; // RL19
            end else if (mode == `SBPRX_PAR_MARK) begin
                parity_bad = ~pbit; // RL20
            end else if (mode == `SBPRX_PAR_SPACE) begin
                parity_bad = pbit; // RL20
            end else if (mode == `SBPRX_PAR_NONE) begin
                parity_bad = 1'b0; // RL21
            end else begin
                parity_bad = pbit; // RL23
            end
        end
    endfunction

    // Expected preamble bit for a given position
    function pre_bit;
        input [1:0] pat;
        input [3:0] idx;
        begin
            if (pat == `SBPRX_PP_ONES) begin // RL24
                pre_bit = 1'b1;
            end else if (pat == `SBPRX_PP_ZEROS) begin
                pre_bit = 1'b0;
            end else if (pat == `SBPRX_PP_ONEZERO) begin
                pre_bit = ~idx[0];
            end else begin
                pre_bit = idx[0];
            end
        end
    endfunction

    // Two-flop synchronisers for the line and the baud clock
    always @(posedge clk) begin
        if (rst) begin
            lineSync <= 2'h3;
            baudSync <= 2'h0;
            baudPrev <= 1'b0;
        end else begin
            lineSync <= {lineSync[0], serialInputLine};
            baudSync <= {baudSync[0], baudClockIn};
            baudPrev <= baudSync[1];
        end
    end

    // APB slave: single-wait answer, registers and reads
    always @(posedge clk) begin
        if (rst) begin
            pready           <= 1'b0;
            pslverr          <= 1'b0;
            prdata           <= 32'h00000000;
            lineConfigReg    <= `SBPRX_CFG_RESET;
            biphaseConfigReg <= `SBPRX_BIP_RESET;
            baudDiv          <= `SBPRX_DIV_RESET;
            rxEnabled        <= 1'b0;
        end else begin
            pready  <= psel & penable & ~pready;
            pslverr <= 1'b0;
            if (psel & penable & ~pready) begin
                prdata <= 32'h00000000;
                if (paddr == `SBPRX_COMMAND_ADDR) begin
                    prdata <= 32'h00000000;
                end else if (paddr == `SBPRX_LINE_CONFIG_ADDR) begin
                    prdata <= lineConfigReg;
                end else if (paddr == `SBPRX_BIPHASE_CONFIG_ADDR) begin
                    prdata <= biphaseConfigReg;
                end else if (paddr == `SBPRX_BAUD_DIV_ADDR) begin
                    prdata <= {16'h0000, baudDiv};
                end else if (paddr == `SBPRX_STATUS_ADDR) begin
                    prdata[`SBPRX_ST_RECEIVE_CHAR_WAITING_BIT] <= receiveCharWaiting;
                    prdata[`SBPRX_ST_OVR_BIT]   <= overrunFlag;
                    prdata[`SBPRX_ST_PAR_BIT]   <= parityErrorFlag;
                    prdata[`SBPRX_ST_CODE_VIOLATION_FLAG_BIT]  <= codeViolationFlag;
                end else if (paddr == `SBPRX_HOLDING_ADDR) begin
                    prdata <= {16'h0000, receivedSyncKind, 7'h00, receivedCharField}; // RL13
                end else begin
                    pslverr <= 1'b1;
                end
            end
            if (apbWrite) begin
                if (paddr == `SBPRX_LINE_CONFIG_ADDR) begin
                    lineConfigReg <= pwdata;
                end else if (paddr == `SBPRX_BIPHASE_CONFIG_ADDR) begin
                    biphaseConfigReg <= pwdata;
                end else if (paddr == `SBPRX_BAUD_DIV_ADDR) begin
                    baudDiv <= pwdata[15:0];
                end else if (paddr == `SBPRX_COMMAND_ADDR) begin
                    if (pwdata[`SBPRX_CMD_RX_DIS_BIT]) begin
                        rxEnabled <= 1'b0;
                    end else if (pwdata[`SBPRX_CMD_RX_EN_BIT]) begin
                        rxEnabled <= 1'b1;
                    end
                end
            end
        end
    end

    // Status flags: a hardware set wins over a clear in the same cycle
    always @(posedge clk) begin
        if (rst) begin
            receiveCharWaiting <= 1'b0;
            overrunFlag        <= 1'b0;
            parityErrorFlag    <= 1'b0;
            codeViolationFlag  <= 1'b0;
            receivedCharField  <= 8'h00;
            receivedSyncKind   <= 1'b0;
        end else begin
            if (clearCmd) begin
                overrunFlag       <= 1'b0;
                parityErrorFlag   <= 1'b0;
                codeViolationFlag <= 1'b0;
            end
            if (rhrRead) begin
                receiveCharWaiting <= 1'b0;
            end
            if (violation) begin
                codeViolationFlag <= 1'b1; // RL12
            end
            if (charDone) begin
                receivedCharField  <= doneChar; // RL16
                receivedSyncKind   <= doneSync; // RL13
                receiveCharWaiting <= 1'b1; // RL16
                if (receiveCharWaiting) begin
                    overrunFlag <= 1'b1; // RL17
                end
                if (doneParErr) begin
                    parityErrorFlag <= 1'b1; // RL22
                end
            end
        end
    end

    // Receive engine: biphase cells or synchronous baud-edge samples
    always @(posedge clk) begin
        if (rst) begin
            state      <= S_IDLE;
            cellCnt    <= 16'h0000;
            bitCnt     <= 4'h0;
            shiftReg   <= 8'h00;
            firstHalf  <= 1'b0;
            syncKind   <= 1'b0;
            charDone   <= 1'b0;
            doneParErr <= 1'b0;
            doneSync   <= 1'b0;
            doneChar   <= 8'h00;
            violation  <= 1'b0;
        end else begin
            charDone  <= 1'b0;
            violation <= 1'b0;
            if (!rxEnabled) begin
                state <= S_IDLE;
            end else if (!biphaseOn) begin // RL1
                // Synchronous mode path
                if (syncMode && baudRise) begin // RL15
                    if (state == S_IDLE) begin
                        if (!lineSync[1]) begin
                            state  <= S_DATA;
                            bitCnt <= 4'h0;
                        end
                    end else if (state == S_DATA) begin
                        shiftReg <= {lineSync[1], shiftReg[7:1]};
                        bitCnt   <= bitCnt + 4'h1;
                        if (bitCnt == `SBPRX_DATA_BITS - 4'h1) begin
                            state <= (parMode == `SBPRX_PAR_NONE) ? S_STOP : S_PAR;
                        end
                    end else if (state == S_PAR) begin
                        doneParErr <= parity_bad(parMode, shiftReg, lineSync[1]);
                        state      <= S_STOP;
                    end else begin
                        if (parMode == `SBPRX_PAR_NONE) begin
                            doneParErr <= 1'b0; // RL21
                        end
                        doneChar <= shiftReg;
                        doneSync <= 1'b0;
                        charDone <= 1'b1;
                        state    <= S_IDLE;
                    end
                end
            end else begin
                // Biphase decoder
                cellCnt <= cellCnt + 16'h0001;
                case (state)
                    S_IDLE: begin
                        // Low for a quarter bit; any high sample restarts the count
                        if (lineIn) begin
                            cellCnt <= 16'h0000;
                        end else if (cellCnt == quarter - 16'h0001) begin // RL7
                            // Quarter point of the first cell reached
                            cellCnt   <= quarter;
                            bitCnt    <= 4'h0;
                            firstHalf <= 1'b0;
                            state     <= (preLen == 4'h0) ? S_DELIM : S_PRE; // RL2
                        end
                    end
                    S_PRE, S_DELIM, S_DATA, S_PAR: begin
                        if (cellCnt == quarter) begin
                            firstHalf <= lineIn; // RL8
                        end
                        if (cellCnt == qtr3) begin // RL10
                            // Decide on three-quarter sample; the bit is the first-half level
                            if (state == S_DELIM && !single_bit_delimiter && bitCnt == 4'h0) begin
                                // Sync: first cell has no mid transition
                                if (firstHalf == lineIn) begin // RL6
                                    syncKind <= firstHalf; // RL25
                                    bitCnt   <= 4'h1;
                                end else begin
                                    state <= S_IDLE; // RL9
                                end
                            end else if (state == S_DELIM && !single_bit_delimiter) begin
                                // Second cell: transition at its middle, then third cell
                                if (bitCnt == 4'h1 && firstHalf == syncKind
                                    && lineIn != syncKind) begin
                                    bitCnt <= 4'h2;
                                end else if (bitCnt == 4'h2 && firstHalf == lineIn
                                             && lineIn != syncKind) begin
                                    state  <= S_DATA; // RL11
                                    bitCnt <= 4'h0;
                                end else begin
                                    state <= S_IDLE; // RL9
                                end
                            end else if (firstHalf == lineIn) begin
                                if (state == S_DATA || state == S_PAR) begin
                                    violation <= 1'b1; // RL12
                                end
                                state <= S_IDLE; // RL9
                            end else if (state == S_PRE) begin
                                if (firstHalf != pre_bit(prePat, bitCnt)) begin // RL4
                                    state <= S_IDLE; // RL9
                                end else if (bitCnt == preLen - 4'h1) begin
                                    state  <= S_DELIM;
                                    bitCnt <= 4'h0;
                                end else begin
                                    bitCnt <= bitCnt + 4'h1;
                                end
                            end else if (state == S_DELIM) begin
                                if (!firstHalf) begin // RL5
                                    state    <= S_DATA; // RL11
                                    bitCnt   <= 4'h0;
                                    syncKind <= 1'b0;
                                end else begin
                                    state <= S_IDLE; // RL9
                                end
                            end else if (state == S_DATA) begin
                                shiftReg <= {firstHalf, shiftReg[7:1]}; // RL11
                                bitCnt   <= bitCnt + 4'h1;
                                if (bitCnt == `SBPRX_DATA_BITS - 4'h1) begin
                                    state <= (parMode == `SBPRX_PAR_NONE) ? S_STOP : S_PAR;
                                    doneParErr <= 1'b0;
                                end
                            end else begin
                                doneParErr <= parity_bad(parMode, shiftReg, firstHalf);
                                state      <= S_STOP;
                            end
                        end
                        if (cellCnt == cellLen - 16'h0001) begin
                            cellCnt <= 16'h0000;
                        end
                    end
                    default: begin
                        // Character complete
                        doneChar  <= shiftReg;
                        doneSync  <= syncKind & ~single_bit_delimiter; // RL13
                        charDone  <= 1'b1;
                        state     <= S_IDLE;
                    end
                endcase
            end
        end
    end
endmodule // sbprx_receiver

// *** bench/sbprx_rx_monitor.sv ***
// Port-level assertions for the serial receive path
`include "sbprx_defines.vh"
module sbprx_rx_monitor (
    input wire        clk,
    input wire        rst,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire        serialInputLine,
    input wire        baudClockIn,
    input wire        receiveCharWaiting
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Decoded register map and holding-register read completion
    wire mapped = (paddr == `SBPRX_COMMAND_ADDR) || (paddr == `SBPRX_LINE_CONFIG_ADDR) ||
                  (paddr == `SBPRX_STATUS_ADDR) || (paddr == `SBPRX_HOLDING_ADDR) ||
                  (paddr == `SBPRX_BAUD_DIV_ADDR) || (paddr == `SBPRX_BIPHASE_CONFIG_ADDR);
    wire holdRead = pready && psel && penable && !pwrite && (paddr == `SBPRX_HOLDING_ADDR);
    sequence s_setup; psel && !penable; endsequence
    sequence s_access; psel && penable; endsequence
    property p_ready_after_access; s_setup ##1 s_access |=> pready; endproperty
    property p_ready_pulse; pready |=> !pready; endproperty
    property p_err_with_ready; pslverr |-> pready; endproperty
    property p_ready_needs_access; pready |-> $past(psel && penable); endproperty
    property p_unmapped_err; pready && !mapped |-> pslverr; endproperty
    property p_mapped_ok; pready && mapped |-> !pslverr; endproperty
    property p_waiting_holds; receiveCharWaiting && !holdRead |=> receiveCharWaiting; endproperty
    property p_read_clears; holdRead |=> !receiveCharWaiting; endproperty
    a_ready_after_access: assert property (p_ready_after_access) else $error("no answer");
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready too long");
    a_err_with_ready: assert property (p_err_with_ready) else $error("stray slave error");
    a_ready_needs_access: assert property (p_ready_needs_access) else $error("stray ready");
    a_unmapped_err: assert property (p_unmapped_err) else $error("unmapped accepted");
    a_mapped_ok: assert property (p_mapped_ok) else $error("mapped refused");
    a_waiting_holds: assert property (p_waiting_holds) else $error("waiting lost");
    a_read_clears: assert property (p_read_clears) else $error("waiting kept");
endmodule // sbprx_rx_monitor
bind sbprx_receiver sbprx_rx_monitor u_mon (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .serialInputLine(serialInputLine),
    .baudClockIn(baudClockIn), .receiveCharWaiting(receiveCharWaiting));

// *** bench/sbprx_far_transmitter.sv ***
// Remote transmitter driving the receive line and baud clock, in synchronous bits or biphase cells
module sbprx_far_transmitter (
    output logic serialInputLine,
    output logic baudClockIn
);
    timeunit 1ns;
    timeprecision 100ps;
    // Frame kind: synchronous bits or biphase cells
    logic biphase = 1'b0;
    // Line idles high, clock stands low between frames
    initial begin
        serialInputLine = 1'b1;
        baudClockIn = 1'b0;
    end
    // One bit: line moves while the clock is low, sampled on the rise
    task automatic sendBit(input logic b);
        serialInputLine = b;
        #35 baudClockIn = 1'b1;
        #35 baudClockIn = 1'b0;
    endtask
    // Biphase cell of 640 ns (four quarters of 16 clocks): bit, then its inverse
    task automatic sendCell(input logic b);
        serialInputLine = b;
        #320 serialInputLine = ~b;
        #320;
    endtask
    // Start, eight data bits LSB first; synchronous frames add optional parity and one stop
    task automatic sendFrame(input logic [7:0] d, input logic usePar, input logic pbit);
        #2;
        if (biphase) begin
            sendCell(1'b0);
            for (int i = 0; i < 8; i++) sendCell(d[i]);
            serialInputLine = 1'b1;
        end else begin
            sendBit(1'b0);
            for (int i = 0; i < 8; i++) sendBit(d[i]);
            if (usePar) sendBit(pbit);
            sendBit(1'b1);
        end
    endtask
endmodule // sbprx_far_transmitter

// *** bench/tb_serial_receiver_biphase_parity.sv ***
// Register-level bench for the serial receive path in synchronous and biphase modes
`include "sbprx_defines.vh"
module tb_serial_receiver_biphase_parity;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk, rst, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic        serialInputLine, baudClockIn, receiveCharWaiting, rerr;
    int          fail_count = 0, tests_run = 0;
    logic [2:0]  modes [6] = '{`SBPRX_PAR_EVEN, `SBPRX_PAR_ODD, `SBPRX_PAR_SPACE,
                               `SBPRX_PAR_MARK, `SBPRX_PAR_NONE, 3'h6};
    logic        goodPar [6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
    sbprx_receiver DUT (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .serialInputLine(serialInputLine), .baudClockIn(baudClockIn),
        .receiveCharWaiting(receiveCharWaiting));
    sbprx_far_transmitter partner (.serialInputLine(serialInputLine), .baudClockIn(baudClockIn));
    // Clock source
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic test_done();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // One APB transfer; answer taken at the edge where pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            n++;
            if (n > 20) begin fail_count++; test_done(); end
            @(posedge clk);
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic checkWord(input logic [31:0] got, exp, mask, input string what);
        tests_run++;
        if ((got & mask) !== (exp & mask)) begin
            fail_count++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic checkFlag(input logic got, exp, input string what);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %s got %b", $time, what, got);
        end
    endtask
    // Send one character, wait for completion, compare status flags
    task automatic recv(input logic [7:0] d, input logic useP, p, input logic [31:0] st);
        int n;
        n = 0;
        partner.sendFrame(d, useP, p);
        while (receiveCharWaiting !== 1'b1) begin
            n++;
            if (n > 200) begin fail_count++; test_done(); end
            @(posedge clk);
        end
        repeat (10) @(posedge clk);
        apb(1'b0, `SBPRX_STATUS_ADDR, 32'h0);
        checkWord(rdat, st, 32'h010000a1, "status");
    endtask
    initial begin
        rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
        pwdata = 32'h0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        // Reset values and an unmapped address
        apb(1'b0, `SBPRX_STATUS_ADDR, 32'h0);
        checkWord(rdat, 32'h0, 32'h010000a1, "status reset");
        apb(1'b0, `SBPRX_LINE_CONFIG_ADDR, 32'h0);
        checkWord(rdat, `SBPRX_CFG_RESET, 32'hffffffff, "config reset");
        apb(1'b0, `SBPRX_BAUD_DIV_ADDR, 32'h0);
        checkWord(rdat, {16'h0000, `SBPRX_DIV_RESET}, 32'h0000ffff, "divider reset");
        apb(1'b0, 12'h0fc, 32'h0);
        checkFlag(rerr, 1'b1, "unmapped error");
        $display("test reset done");
        apb(1'b1, `SBPRX_COMMAND_ADDR, 32'h00000010);
        // Every check-bit mode with a right and a wrong parity bit; the no-parity mode sends no parity bit
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, `SBPRX_LINE_CONFIG_ADDR, 32'h00000100 | (32'(modes[i]) << 9));
            recv(8'h41, modes[i] != `SBPRX_PAR_NONE, goodPar[i], 32'h01);
            apb(1'b0, `SBPRX_HOLDING_ADDR, 32'h0);
            checkWord(rdat, 32'h41, 32'h000000ff, "char");
            @(posedge clk);
            checkFlag(receiveCharWaiting, 1'b0, "waiting after read");
            recv(8'h41, modes[i] != `SBPRX_PAR_NONE, ~goodPar[i],
                 (modes[i] == `SBPRX_PAR_NONE) ? 32'h01 : 32'h81);
            apb(1'b1, `SBPRX_COMMAND_ADDR, 32'h00000100);
            apb(1'b0, `SBPRX_STATUS_ADDR, 32'h0);
            checkWord(rdat, 32'h01, 32'h010000a1, "after clear");
            apb(1'b0, `SBPRX_HOLDING_ADDR, 32'h0);
            $display("test parity mode %0d done", modes[i]);
        end
        // Two characters without a read in between
        apb(1'b1, `SBPRX_LINE_CONFIG_ADDR, 32'h00000100 | (32'(`SBPRX_PAR_NONE) << 9));
        recv(8'h5a, 1'b0, 1'b0, 32'h01);
        recv(8'ha5, 1'b0, 1'b0, 32'h21);
        apb(1'b1, `SBPRX_COMMAND_ADDR, 32'h00000100);
        apb(1'b0, `SBPRX_STATUS_ADDR, 32'h0);
        checkWord(rdat, 32'h01, 32'h010000a1, "overrun cleared");
        apb(1'b0, `SBPRX_HOLDING_ADDR, 32'h0);
        checkWord(rdat, 32'ha5, 32'h000000ff, "overwritten char");
        $display("test overrun done");
        // Biphase frame: one-bit delimiter, no preamble, no parity
        partner.biphase = 1'b1;
        apb(1'b1, `SBPRX_LINE_CONFIG_ADDR, 32'ha0000800);
        recv(8'h4b, 1'b0, 1'b0, 32'h01);
        apb(1'b0, `SBPRX_HOLDING_ADDR, 32'h0);
        checkWord(rdat, 32'h4b, 32'h000080ff, "biphase char");
        $display("test biphase done");
        test_done();
    end
endmodule // tb_serial_receiver_biphase_parity
